// ---- hw/alarm_interrupt.sv ----
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - match sets alarm flag, drives interrupt low
// - interrupt stays low until software cancels
// - clock halt blocks all alarm events
// - select zero: weekday bit mask compare
// - select one: BCD day-of-month compare
// - week/day exclude: match time only
// - all four excluded: event every second
// - writing current time gives no event
// - flag sticky, write zero clears, one ignored
// - clearing flag releases interrupt pin
// - enable gates pin low, zero releases
// - enable gates pin only, flag kept
// - BCD compare registers with exclude bit 7
// - exclude bit removes field from compare
module alarm_interrupt
	import alarm_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// one-second calendar tick
	input wire logic second_tick,
	// other interrupt sources sharing the pin (already enabled)
	input wire logic other_irq,
	// open-drain interrupt pin
	input wire logic int_n_in,
	output logic int_n_out,
	output logic int_n_oe,
	// level interrupt to the system
	output logic irq
);
	import alarm_pkg::*;

	// ==========================================================
	// register state
	logic [7:0] second_alarm_compare;
	logic [7:0] min_alarm;
	logic [7:0] hour_alarm;
	logic [7:0] wday_alarm;
	logic [7:0] extension;
	logic [7:0] control;
	logic alarm_event_flag;
	logic [7:0] cal_sec;
	logic [7:0] cal_min;
	logic [7:0] cal_hour;
	logic [6:0] cal_week;
	logic [7:0] cal_day;
	logic advanced;
	logic irq_status;
	logic irq_mask;
	logic prev_match;

	// ==========================================================
	// axi write channel
	logic aw_held;
	logic w_held;
	logic [3:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane0;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_held || aw_take;
	wire w_have = w_held || w_take;
	wire do_write = aw_have && w_have && !s_axi_bvalid;
	wire [3:0] wr_idx = aw_held ? aw_idx : s_axi_awaddr[5:2];
	wire [7:0] wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
	wire wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
	wire wr_en = do_write && wr_lane0;

	// address decode of the write
	wire wr_known = (wr_idx == IDX_MIN_ALARM) || (wr_idx == IDX_HOUR_ALARM) ||
		(wr_idx == IDX_WDAY_ALARM) || (wr_idx == IDX_SECOND_ALARM_COMPARE) ||
		(wr_idx == IDX_EXTENSION) || (wr_idx == IDX_FLAGS) ||
		(wr_idx == IDX_CONTROL) || (wr_idx == IDX_CAL_SEC) ||
		(wr_idx == IDX_CAL_MIN) || (wr_idx == IDX_CAL_HOUR) ||
		(wr_idx == IDX_CAL_WEEK) || (wr_idx == IDX_CAL_DAY) ||
		(wr_idx == IDX_TICK) || (wr_idx == IDX_IRQ_STATUS) ||
		(wr_idx == IDX_IRQ_MASK);
	wire wr_sel_flags = wr_en && (wr_idx == IDX_FLAGS);
	wire wr_sel_cal = wr_en && ((wr_idx == IDX_CAL_SEC) || (wr_idx == IDX_CAL_MIN) ||
		(wr_idx == IDX_CAL_HOUR) || (wr_idx == IDX_CAL_WEEK) || (wr_idx == IDX_CAL_DAY));

	// capture address and data, issue response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= 4'h0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			else
			begin
				if (aw_take)
				begin
					aw_held <= 1'b1;
					aw_idx <= s_axi_awaddr[5:2];
				end
				if (w_take)
				begin
					w_held <= 1'b1;
					w_byte <= s_axi_wdata[7:0];
					w_lane0 <= s_axi_wstrb[0];
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// software-written registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			second_alarm_compare <= ALARM_RESET;
			min_alarm <= ALARM_RESET;
			hour_alarm <= ALARM_RESET;
			wday_alarm <= ALARM_RESET;
			extension <= ALARM_RESET;
			control <= CONTROL_RESET;
			irq_mask <= 1'b0;
		end
		else if (wr_en)
		begin
			if (wr_idx == IDX_SECOND_ALARM_COMPARE)
				second_alarm_compare <= wr_byte;
			if (wr_idx == IDX_MIN_ALARM)
				min_alarm <= wr_byte;
			if (wr_idx == IDX_HOUR_ALARM)
				hour_alarm <= wr_byte;
			if (wr_idx == IDX_WDAY_ALARM)
				wday_alarm <= wr_byte;
			if (wr_idx == IDX_EXTENSION)
				extension <= wr_byte;
			if (wr_idx == IDX_CONTROL)
				control <= wr_byte;
			if (wr_idx == IDX_IRQ_MASK)
				irq_mask <= wr_byte[0];
		end
	end

	// ==========================================================
	// running calendar, loaded by software, advanced by tick
	wire tick = second_tick || (wr_en && (wr_idx == IDX_TICK) && wr_byte[0]);
	wire halted = control[CLOCK_HALT_BIT];
	wire advance = tick && !halted && !wr_sel_cal;

	// bcd increment with wrap at limit
	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
		input logic [7:0] first);
		logic [7:0] r;
		r = 8'h00;
		if (v == last)
			r = first;
		else if (v[3:0] == 4'h9)
			r = {v[7:4] + 4'h1, 4'h0};
		else
			r = {v[7:4], v[3:0] + 4'h1};
		return r;
	endfunction

	wire sec_wrap = (cal_sec == 8'h59);
	wire min_wrap = sec_wrap && (cal_min == 8'h59);
	wire hour_wrap = min_wrap && (cal_hour == 8'h23);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cal_sec <= 8'h00;
			cal_min <= 8'h00;
			cal_hour <= 8'h00;
			cal_week <= CAL_WEEK_RESET[6:0];
			cal_day <= CAL_DAY_RESET;
		end
		else if (wr_sel_cal)
		begin
			if (wr_idx == IDX_CAL_SEC)
				cal_sec <= wr_byte;
			if (wr_idx == IDX_CAL_MIN)
				cal_min <= wr_byte;
			if (wr_idx == IDX_CAL_HOUR)
				cal_hour <= wr_byte;
			if (wr_idx == IDX_CAL_WEEK)
				cal_week <= wr_byte[6:0];
			if (wr_idx == IDX_CAL_DAY)
				cal_day <= wr_byte;
		end
		else if (advance)
		begin
			cal_sec <= bcd_inc(cal_sec, 8'h59, 8'h00);
			if (sec_wrap)
				cal_min <= bcd_inc(cal_min, 8'h59, 8'h00);
			if (min_wrap)
				cal_hour <= bcd_inc(cal_hour, 8'h23, 8'h00);
			if (hour_wrap)
			begin
				cal_week <= {cal_week[5:0], cal_week[6]};
				cal_day <= bcd_inc(cal_day, 8'h31, 8'h01);
			end
		end
	end

	// ==========================================================
	// alarm compare; excluded fields always match
	wire sec_hit = second_alarm_compare[MATCH_EXCLUDE_BIT] || (second_alarm_compare[6:0] == cal_sec[6:0]);
	wire min_hit = min_alarm[MATCH_EXCLUDE_BIT] || (min_alarm[6:0] == cal_min[6:0]);
	wire hour_hit = hour_alarm[MATCH_EXCLUDE_BIT] || (hour_alarm[5:0] == cal_hour[5:0]);
	wire week_hit = |(wday_alarm[6:0] & cal_week);
	wire day_hit = (wday_alarm[5:0] == cal_day[5:0]);
	wire wday_hit = wday_alarm[MATCH_EXCLUDE_BIT] ||
		(extension[WEEKDAY_OR_DATE_BIT] ? day_hit : week_hit);
	wire match_now = sec_hit && min_hit && hour_hit && wday_hit;
	wire all_excluded = second_alarm_compare[MATCH_EXCLUDE_BIT] && min_alarm[MATCH_EXCLUDE_BIT] &&
		hour_alarm[MATCH_EXCLUDE_BIT] && wday_alarm[MATCH_EXCLUDE_BIT];

	// compare one cycle after the advance, against the time just entered
	wire alarm_event = advanced && !halted &&
		(all_excluded || (match_now && !prev_match));

	// match state kept per advance only, so writes other than to the tick register never raise an event
	always_ff @(posedge aclk)
	begin
		advanced <= aresetn && advance;
		if (!aresetn)
			prev_match <= 1'b0;
		else if (advanced)
			prev_match <= match_now;
	end

	// ==========================================================
	// sticky flag, set wins over clear
	wire flag_clear = wr_sel_flags && !wr_byte[ALARM_FLAG_BIT];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			alarm_event_flag <= 1'b0;
		else if (alarm_event)
			alarm_event_flag <= 1'b1;
		else if (flag_clear)
			alarm_event_flag <= 1'b0;
	end

	// open-drain pin: low while enabled flag or another source is active
	wire alarm_irq_enable = control[ALARM_IRQ_EN_BIT];
	wire pull_low = (alarm_event_flag && alarm_irq_enable) || other_irq;
	assign int_n_out = 1'b0;
	assign int_n_oe = pull_low;

	// ==========================================================
	// system interrupt: sticky status, write one clears
	wire status_clear = wr_en && (wr_idx == IDX_IRQ_STATUS) && wr_byte[0];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_status <= 1'b0;
		else if (alarm_event)
			irq_status <= 1'b1;
		else if (status_clear)
			irq_status <= 1'b0;
	end
	assign irq = irq_status && irq_mask;

	// ==========================================================
	// axi read channel
	assign s_axi_arready = !s_axi_rvalid;
	wire [3:0] rd_idx = s_axi_araddr[5:2];
	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb
	begin
		rd_ok = 1'b1;
		case (rd_idx)
			IDX_SECOND_ALARM_COMPARE: rd_byte = second_alarm_compare;
			IDX_MIN_ALARM: rd_byte = min_alarm;
			IDX_HOUR_ALARM: rd_byte = hour_alarm;
			IDX_WDAY_ALARM: rd_byte = wday_alarm;
			IDX_EXTENSION: rd_byte = extension;
			IDX_FLAGS: rd_byte = {4'h0, alarm_event_flag, 3'b000};
			IDX_CONTROL: rd_byte = control;
			IDX_CAL_SEC: rd_byte = cal_sec;
			IDX_CAL_MIN: rd_byte = cal_min;
			IDX_CAL_HOUR: rd_byte = cal_hour;
			IDX_CAL_WEEK: rd_byte = {1'b0, cal_week};
			IDX_CAL_DAY: rd_byte = cal_day;
			IDX_TICK: rd_byte = {7'h00, !int_n_in};
			IDX_IRQ_STATUS: rd_byte = {7'h00, irq_status};
			IDX_IRQ_MASK: rd_byte = {7'h00, irq_mask};
			default:
			begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================================
	// checks
	sequence seq_entry;
		advanced && !halted && match_now && !prev_match;
	endsequence

	chk_event_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_entry |=> alarm_event_flag)
		else $error("alarm entry did not set flag");
	chk_halt_no_event: assert property (@(posedge aclk) disable iff (!aresetn)
		halted && !alarm_event_flag |=> !alarm_event_flag)
		else $error("flag set while clock halted");
	chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_event_flag && !flag_clear |=> alarm_event_flag)
		else $error("flag dropped without clear");
	chk_clear_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		flag_clear && !alarm_event && !other_irq ##1 !other_irq |-> !int_n_oe)
		else $error("pin not released after clear");
	chk_pin_low: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_event_flag && alarm_irq_enable |-> int_n_oe && !int_n_out)
		else $error("pin not pulled low");
	chk_enable_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_event_flag && !alarm_irq_enable && !flag_clear |=> alarm_event_flag)
		else $error("enable cleared the flag");
	chk_all_excluded: assert property (@(posedge aclk) disable iff (!aresetn)
		advanced && !halted && all_excluded |=> alarm_event_flag)
		else $error("no event with all excluded");
	chk_no_repeat: assert property (@(posedge aclk) disable iff (!aresetn)
		advanced && prev_match && match_now && !all_excluded |-> !alarm_event)
		else $error("repeat event while matching");
	chk_pin_held: assert property (@(posedge aclk) disable iff (!aresetn)
		int_n_oe && alarm_irq_enable && alarm_event_flag && !flag_clear
		&& !(wr_en && (wr_idx == IDX_CONTROL)) |=> int_n_oe)
		else $error("pin released on its own");
endmodule

// ---- hw/alarm_pkg.sv ----
package alarm_pkg;
	// register byte addresses (printed offsets are not all multiples of four: index * 4)
	localparam logic [3:0] IDX_MIN_ALARM = 4'h7;
	localparam logic [3:0] IDX_HOUR_ALARM = 4'h8;
	localparam logic [3:0] IDX_WDAY_ALARM = 4'h9;
	localparam logic [3:0] IDX_SECOND_ALARM_COMPARE = 4'hc;
	localparam logic [3:0] IDX_EXTENSION = 4'hd;
	localparam logic [3:0] IDX_FLAGS = 4'he;
	localparam logic [3:0] IDX_CONTROL = 4'hf;
	// own registers: running calendar, tick, irq status/mask
	localparam logic [3:0] IDX_CAL_SEC = 4'h0;
	localparam logic [3:0] IDX_CAL_MIN = 4'h1;
	localparam logic [3:0] IDX_CAL_HOUR = 4'h2;
	localparam logic [3:0] IDX_CAL_WEEK = 4'h3;
	localparam logic [3:0] IDX_CAL_DAY = 4'h4;
	localparam logic [3:0] IDX_TICK = 4'h5;
	localparam logic [3:0] IDX_IRQ_STATUS = 4'h6;
	localparam logic [3:0] IDX_IRQ_MASK = 4'ha;
	// field positions
	localparam int MATCH_EXCLUDE_BIT = 7;
	localparam int WEEKDAY_OR_DATE_BIT = 3;
	localparam int ALARM_FLAG_BIT = 3;
	localparam int ALARM_IRQ_EN_BIT = 3;
	localparam int CLOCK_HALT_BIT = 0;
	// reset values
	localparam logic [7:0] ALARM_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CAL_DAY_RESET = 8'h01;
	localparam logic [7:0] CAL_WEEK_RESET = 8'h01;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- verif/axi_host.sv ----
`timescale 1ns/1ps
// ==========
// axi4-lite host, one access at a time
module axi_host
(
	// clock
	input wire logic aclk,
	// write side
	output logic [5:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read side
	output logic [5:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// idle bus from time zero, only byte lane 0 carries data
	initial
	begin
		s_axi_awaddr = 6'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h1;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 6'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end
	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [3:0] idx, input logic [7:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask
	// read: address held until taken, data taken with rvalid
	task automatic rd(input logic [3:0] idx, output logic [7:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata[7:0];
		resp = s_axi_rresp;
	endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
// ==========
// alarm interrupt bench
module tb_top;
	import alarm_pkg::*;
	// one case: alarm values, select, calendar, flag after each of two ticks
	typedef struct packed {logic [7:0] sa, ma, ha, wa; logic weekday_or_date_select;
		logic [7:0] mi, hr, wk, dy; logic e1, e2;} row_t;
	logic aclk, aresetn, second_tick, other_irq, int_n_in, int_n_out, int_n_oe, irq;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] d;
	int num_errors = 0;
	int samples_checked = 0;
	row_t rows [9] = '{
		'{8'h30, 8'h59, 8'h18, 8'h7f, 1'b0, 8'h59, 8'h18, 8'h01, 8'h01, 1'b0, 1'b1},
		'{8'h30, 8'h59, 8'h18, 8'h02, 1'b0, 8'h59, 8'h18, 8'h01, 8'h01, 1'b0, 1'b0},
		'{8'h30, 8'h59, 8'h18, 8'h02, 1'b0, 8'h59, 8'h18, 8'h02, 8'h01, 1'b0, 1'b1},
		'{8'h30, 8'h59, 8'h18, 8'h15, 1'b1, 8'h59, 8'h18, 8'h01, 8'h15, 1'b0, 1'b1},
		'{8'h30, 8'h59, 8'h18, 8'h15, 1'b1, 8'h59, 8'h18, 8'h01, 8'h14, 1'b0, 1'b0},
		'{8'h30, 8'h59, 8'h18, 8'h80, 1'b0, 8'h59, 8'h18, 8'h40, 8'h09, 1'b0, 1'b1},
		'{8'h30, 8'h59, 8'h80, 8'h80, 1'b0, 8'h59, 8'h05, 8'h01, 8'h01, 1'b0, 1'b1},
		'{8'h30, 8'h58, 8'h18, 8'h80, 1'b0, 8'h59, 8'h18, 8'h01, 8'h01, 1'b0, 1'b0},
		'{8'h80, 8'h80, 8'h80, 8'h80, 1'b0, 8'h59, 8'h18, 8'h01, 8'h01, 1'b1, 1'b1}
	};
	// pull-up on the shared open-drain pin
	assign int_n_in = int_n_oe ? int_n_out : 1'b1;
	alarm_interrupt u_alarm_interrupt (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .second_tick, .other_irq,
		.int_n_in, .int_n_out, .int_n_oe, .irq);
	axi_host u_axi_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// 125 mhz clock
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// ==========
	// helpers
	task automatic w(input logic [3:0] idx, input logic [7:0] v);
		u_axi_host.wr(idx, v, resp);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// read flags and compare the alarm flag alone
	task automatic rf(input logic e);
		u_axi_host.rd(IDX_FLAGS, d, resp);
		chk(d & 8'h08, {4'h0, e, 3'h0});
	endtask
	task automatic tick();
		second_tick <= 1'b1;
		@(posedge aclk);
		second_tick <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog
	initial
	begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		wrap_up();
	end
	// ==========
	// main sequence
	initial
	begin
		aresetn <= 1'b0;
		second_tick <= 1'b0;
		other_irq <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i])
		begin
			w(IDX_CONTROL, 8'h00);
			w(IDX_FLAGS, 8'h00);
			w(IDX_SECOND_ALARM_COMPARE, rows[i].sa);
			w(IDX_MIN_ALARM, rows[i].ma);
			w(IDX_HOUR_ALARM, rows[i].ha);
			w(IDX_WDAY_ALARM, rows[i].wa);
			w(IDX_EXTENSION, {4'h0, rows[i].weekday_or_date_select, 3'h0});
			w(IDX_CAL_SEC, 8'h28);
			w(IDX_CAL_MIN, rows[i].mi);
			w(IDX_CAL_HOUR, rows[i].hr);
			w(IDX_CAL_WEEK, rows[i].wk);
			w(IDX_CAL_DAY, rows[i].dy);
			w(IDX_CONTROL, 8'h08);
			tick();
			rf(rows[i].e1);
			tick();
			rf(rows[i].e2);
			chk({7'h00, int_n_oe}, {7'h00, rows[i].e2});
		end
		$display("[END] table");
		w(IDX_CONTROL, 8'h00);
		chk({7'h00, int_n_oe}, 8'h00);
		rf(1'b1);
		w(IDX_CONTROL, 8'h08);
		chk({7'h00, int_n_oe}, 8'h01);
		w(IDX_FLAGS, 8'h08);
		rf(1'b1);
		w(IDX_FLAGS, 8'h00);
		rf(1'b0);
		chk({7'h00, int_n_oe}, 8'h00);
		$display("[END] flag and enable");
		w(IDX_IRQ_MASK, 8'h01);
		chk({7'h00, irq}, 8'h01);
		w(IDX_IRQ_STATUS, 8'h01);
		chk({7'h00, irq}, 8'h00);
		w(IDX_IRQ_MASK, 8'h00);
		other_irq <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
		chk({6'h00, int_n_oe, int_n_out}, 8'h02);
		u_axi_host.rd(IDX_TICK, d, resp);
		chk(d, 8'h01);
		other_irq <= 1'b0;
		$display("[END] irq and shared pin");
		w(IDX_CONTROL, 8'h09);
		tick();
		rf(1'b0);
		w(IDX_CONTROL, 8'h08);
		tick();
		rf(1'b1);
		w(IDX_CONTROL, 8'h00);
		w(IDX_FLAGS, 8'h00);
		w(IDX_MIN_ALARM, 8'hc5);
		u_axi_host.rd(IDX_MIN_ALARM, d, resp);
		chk(d, 8'hc5);
		tick();
		chk({7'h00, int_n_oe}, 8'h00);
		w(IDX_FLAGS, 8'h00);
		w(IDX_SECOND_ALARM_COMPARE, 8'h30);
		w(IDX_MIN_ALARM, 8'h59);
		w(IDX_HOUR_ALARM, 8'h18);
		w(IDX_CAL_SEC, 8'h30);
		w(IDX_CAL_MIN, 8'h59);
		w(IDX_CAL_HOUR, 8'h18);
		w(IDX_TICK, 8'h01);
		u_axi_host.rd(IDX_CAL_SEC, d, resp);
		chk(d, 8'h31);
		rf(1'b0);
		$display("[END] halt, storage, same time");
		u_axi_host.rd(4'hb, d, resp);
		chk({6'h00, resp}, {6'h00, RESP_SLVERR});
		u_axi_host.wr(4'hb, 8'h01, resp);
		chk({6'h00, resp}, {6'h00, RESP_SLVERR});
		$display("[END] unmapped");
		w(IDX_CONTROL, 8'h08);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		u_axi_host.rd(IDX_CONTROL, d, resp);
		chk(d, CONTROL_RESET);
		u_axi_host.rd(IDX_SECOND_ALARM_COMPARE, d, resp);
		chk(d, ALARM_RESET);
		rf(1'b0);
		chk({6'h00, int_n_oe, irq}, 8'h00);
		$display("[END] reset");
		wrap_up();
	end
endmodule
